// ===== dv/phyirq_testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk;
   logic rst;
   phyirq_pkg::phyirq_apb_req_type req;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   phyirq_pkg::phyirq_link_ev_type lev;
   phyirq_pkg::phyirq_supply_ev_type sev;
   phyirq_pkg::phyirq_wake_ev_type wev;
   logic irq_pin;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] rdat;
   logic rerr;
   logic [11:0] ga [3] = '{phyirq_pkg::ADDR_LINK, phyirq_pkg::ADDR_SUPPLY, phyirq_pkg::ADDR_WAKE};
   logic [31:0] base [3] = '{32'h0, 32'h0, 32'h8};
   int pos [3][6] = '{'{10, 11, 13, 14, 15, 0}, '{8, 10, 11, 14, 15, 0}, '{8, 9, 10, 11, 14, 15}};

   phyirq_top dut (.clk(clk), .rst(rst), .apb_req(req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_ev(lev), .supply_ev(sev), .wake_ev(wev), .irq_pin(irq_pin));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_errors++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(32'(pready), 32'h1, "pready");
      rdat = prdata;
      rerr = pslverr;
      req <= '0;
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp, "read");
   endtask : rd

   task automatic pulse(input logic [4:0] l, input logic [4:0] s, input logic [5:0] w);
      @(posedge clk);
      lev <= l;
      sev <= s;
      wev <= w;
      @(posedge clk);
      lev <= '0;
      sev <= '0;
      wev <= '0;
   endtask : pulse

   task automatic pin_is(input logic exp);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(32'(irq_pin), 32'(exp), "irq_pin");
   endtask : pin_is

   task automatic reset_values();
      @(negedge clk);
      chk(32'(irq_pin), 32'h1, "idle pin");
      rd(phyirq_pkg::ADDR_LINK, 32'h0);
      rd(phyirq_pkg::ADDR_SUPPLY, 32'h0);
      rd(phyirq_pkg::ADDR_WAKE, 32'h8);
      rd(phyirq_pkg::ADDR_CONFIG, 32'h8);
      rd(phyirq_pkg::ADDR_CONTROL, 32'h0);
   endtask : reset_values

   task automatic each_event();
      for (int g = 0; g < 3; g++) begin
         for (int i = 0; i < 6; i++) begin
            if (pos[g][i] != 0) begin
               pulse(g == 0 ? 5'(1 << i) : 5'h0, g == 1 ? 5'(1 << i) : 5'h0,
                  g == 2 ? 6'(1 << i) : 6'h0);
               rd(ga[g], (32'h1 << pos[g][i]) | base[g]);
               rd(ga[g], base[g]);
            end
         end
      end
   endtask : each_event

   task automatic enables();
      for (int g = 0; g < 3; g++) begin
         apb(1'b1, ga[g], 32'hffffffff);
      end
      rd(phyirq_pkg::ADDR_LINK, 32'hec);
      rd(phyirq_pkg::ADDR_SUPPLY, 32'hcc);
      rd(phyirq_pkg::ADDR_WAKE, 32'hcf);
   endtask : enables

   task automatic pin_paths();
      apb(1'b1, phyirq_pkg::ADDR_CONFIG, 32'ha);
      pin_is(1'b1);
      pulse(5'h01, 5'h0, 6'h0);
      pin_is(1'b0);
      rd(phyirq_pkg::ADDR_CONTROL, 32'h80);
      rd(phyirq_pkg::ADDR_LINK, 32'h4ec);
      pin_is(1'b1);
      rd(phyirq_pkg::ADDR_LINK, 32'hec);
      rd(phyirq_pkg::ADDR_CONTROL, 32'h0);
      pulse(5'h0, 5'h01, 6'h0);
      pin_is(1'b1);
      rd(phyirq_pkg::ADDR_SUPPLY, 32'h1cc);
      apb(1'b1, phyirq_pkg::ADDR_CONFIG, 32'h8);
      pulse(5'h0, 5'h0, 6'h02);
      pin_is(1'b1);
      rd(phyirq_pkg::ADDR_WAKE, 32'h2cf);
      apb(1'b1, phyirq_pkg::ADDR_CONFIG, 32'hc);
      pin_is(1'b0);
      apb(1'b1, phyirq_pkg::ADDR_CONFIG, 32'hf);
      rd(phyirq_pkg::ADDR_CONFIG, 32'he);
      pin_is(1'b0);
      apb(1'b1, phyirq_pkg::ADDR_CONFIG, 32'h6);
      pin_is(1'b1);
      apb(1'b1, phyirq_pkg::ADDR_CONFIG, 32'h0);
      pin_is(1'b0);
   endtask : pin_paths

   task automatic unmapped();
      apb(1'b1, 12'h050, 32'hffff);
      chk(32'(rerr), 32'h1, "write err");
      rd(12'h050, 32'h0);
      chk(32'(rerr), 32'h1, "read err");
      apb(1'b1, phyirq_pkg::ADDR_LINK, 32'h0);
      chk(32'(rerr), 32'h0, "mapped err");
   endtask : unmapped

   initial begin
      req = '0;
      lev = '0;
      sev = '0;
      wev = '0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      reset_values();
      each_event();
      enables();
      pin_paths();
      unmapped();
      conclude();
   end
endmodule : testbench

// ===== logic/phyirq_pkg.sv
// Summary of operation
// RULE1: Bit 15 of link group flags link quality low, read only, resets zero.
// RULE2: Bit 14 of link group flags a change of detected line energy.
// RULE3: Bit 13 of link group flags any change of link state.
// RULE4: Bit 11 of link group flags an electrostatic discharge fault.
// RULE5: Bit 10 of link group flags completion of link training.
// RULE6: Link group enables in bits 7,6,5,3,2 are writable and reset to zero.
// RULE7: Supply group bit 15 flags undervoltage, bit 14 flags overvoltage.
// RULE8: Supply group bit 11 flags overtemperature.
// RULE9: Supply group bit 10 flags a change of sleep mode state.
// RULE10: Supply group bit 8 flags a state vector not one-hot; no enable.
// RULE11: Supply group enables in bits 7,6,3,2 are writable and reset zero.
// RULE12: Wake group bit 15 flags reception of an acknowledge.
// RULE13: Wake group bit 14 flags clearing of the transmit-valid indication.
// RULE14: Wake group bit 11 flags completion of power-on reset.
// RULE15: Wake group bit 10 flags frame absence.
// RULE16: Wake group bit 9 flags wake request, bit 8 low-power-sleep request.
// RULE17: Wake group enables in bits 7,6,2,1,0 are writable and reset zero.
// RULE18: Wake group power-on-done enable bit 3 resets to one.
// RULE19: Global enable bit in configuration gates all interrupt pin activity; the code lets the force bit assert the pin with it clear.
// RULE20: Pin polarity bit resets to one meaning active low; zero active high.
// RULE21: Force bit asserts the interrupt pin regardless of pending events.
// RULE22: Sticky pin-asserted bit in control, cleared by reading link group.
// RULE23: Pin asserts when a flag and its enable eight bits lower are set.
// RULE24: Each flag latches on its event and clears when its register is read.
package phyirq_pkg;
   // Register indices; the byte address is four times the index
   localparam int IDX_CONTROL = 32'h0000_0010;
   localparam int IDX_CONFIG = 32'h0000_0011;
   localparam int IDX_LINK = 32'h0000_0012;
   localparam int IDX_SUPPLY = 32'h0000_0013;
   localparam int IDX_WAKE = 32'h0000_0018;
   localparam logic [11:0] ADDR_CONTROL = 12'(IDX_CONTROL * 4);
   localparam logic [11:0] ADDR_CONFIG = 12'(IDX_CONFIG * 4);
   localparam logic [11:0] ADDR_LINK = 12'(IDX_LINK * 4);
   localparam logic [11:0] ADDR_SUPPLY = 12'(IDX_SUPPLY * 4);
   localparam logic [11:0] ADDR_WAKE = 12'(IDX_WAKE * 4);
   localparam logic [7:0] EN_MASK_LINK = 8'hec;
   localparam logic [7:0] EN_MASK_SUPPLY = 8'hcc;
   localparam logic [7:0] EN_MASK_WAKE = 8'hcf;
   localparam logic [7:0] EN_RESET_LINK = 8'h00;
   localparam logic [7:0] EN_RESET_SUPPLY = 8'h00;
   localparam logic [7:0] EN_RESET_WAKE = 8'h08;
   localparam logic [7:0] FLAG_MASK_LINK = 8'hec;
   localparam logic [7:0] FLAG_MASK_SUPPLY = 8'hcd;
   localparam logic [7:0] FLAG_MASK_WAKE = 8'hcf;
   localparam int FLAG_LSB = 8;
   localparam int CTRL_PIN_STATUS_BIT = 7;
   localparam int CFG_POLARITY_BIT = 3;
   localparam int CFG_FORCE_BIT = 2;
   localparam int CFG_ENABLE_BIT = 1;
   localparam logic [3:0] CFG_WRITE_MASK = 4'he;
   localparam logic [3:0] CFG_RESET = 4'h8;
   localparam int GROUPS = 3;
   // Event inputs per group, in flag byte order without the unused bits
   typedef struct packed {
      logic link_quality_low;
      logic energy_change;
      logic link_change;
      logic esd_fault;
      logic training_done;
   } phyirq_link_ev_type;
   typedef struct packed {
      logic undervoltage;
      logic overvoltage;
      logic overtemperature;
      logic sleep_change;
      logic not_one_hot;
   } phyirq_supply_ev_type;
   typedef struct packed {
      logic ack_received;
      logic tx_valid_clear;
      logic por_done;
      logic no_frame;
      logic wake_request;
      logic low_power_sleep_request;
   } phyirq_wake_ev_type;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } phyirq_apb_req_type;
endpackage : phyirq_pkg

// ===== logic/phyirq_top.sv
`timescale 1ns/1ps
module phyirq_top (
   input wire logic clk,
   input wire logic rst,
   input phyirq_pkg::phyirq_apb_req_type apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input phyirq_pkg::phyirq_link_ev_type link_ev,
   input phyirq_pkg::phyirq_supply_ev_type supply_ev,
   input phyirq_pkg::phyirq_wake_ev_type wake_ev,
   output logic irq_pin
);
   logic [7:0] flag_reg [phyirq_pkg::GROUPS];
   logic [7:0] flag_next [phyirq_pkg::GROUPS];
   logic [7:0] en_reg [phyirq_pkg::GROUPS];
   logic [7:0] en_next [phyirq_pkg::GROUPS];
   logic [3:0] cfg_reg, cfg_next;
   logic pin_sticky_reg, pin_sticky_next;
   logic irq_reg, irq_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [7:0] ev [phyirq_pkg::GROUPS];
   logic [7:0] fmask [phyirq_pkg::GROUPS];
   logic [7:0] emask [phyirq_pkg::GROUPS];
   logic [7:0] erst [phyirq_pkg::GROUPS];
   logic [11:0] gaddr [phyirq_pkg::GROUPS];
   logic setup, acc_wr, acc_rd, hit, pending, active;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Events mapped onto the flag byte positions (bit n is status bit n+8)
   always_comb begin
      // RULE1 RULE2 RULE3 RULE4 RULE5 link events
      ev[0] = {link_ev.link_quality_low, link_ev.energy_change, link_ev.link_change,
               1'b0, link_ev.esd_fault, link_ev.training_done, 2'b00};
      // RULE7 RULE8 RULE9 RULE10 supply events
      ev[1] = {supply_ev.undervoltage, supply_ev.overvoltage, 2'b00,
               supply_ev.overtemperature, supply_ev.sleep_change, 1'b0,
               supply_ev.not_one_hot};
      // RULE12 RULE13 RULE14 RULE15 RULE16 wake events
      ev[2] = {wake_ev.ack_received, wake_ev.tx_valid_clear, 2'b00, wake_ev.por_done,
               wake_ev.no_frame, wake_ev.wake_request, wake_ev.low_power_sleep_request};
      fmask[0] = phyirq_pkg::FLAG_MASK_LINK;
      fmask[1] = phyirq_pkg::FLAG_MASK_SUPPLY;
      fmask[2] = phyirq_pkg::FLAG_MASK_WAKE;
      emask[0] = phyirq_pkg::EN_MASK_LINK;
      emask[1] = phyirq_pkg::EN_MASK_SUPPLY;
      emask[2] = phyirq_pkg::EN_MASK_WAKE;
      erst[0] = phyirq_pkg::EN_RESET_LINK;
      erst[1] = phyirq_pkg::EN_RESET_SUPPLY;
      erst[2] = phyirq_pkg::EN_RESET_WAKE;
      gaddr[0] = phyirq_pkg::ADDR_LINK;
      gaddr[1] = phyirq_pkg::ADDR_SUPPLY;
      gaddr[2] = phyirq_pkg::ADDR_WAKE;
   end

   // APB decode: one wait-free access phase, answer registered
   always_comb begin
      setup = apb_req.psel && !apb_req.penable;
      acc_wr = setup && apb_req.pwrite;
      acc_rd = setup && !apb_req.pwrite;
      hit = (apb_req.paddr == phyirq_pkg::ADDR_CONTROL)
         || (apb_req.paddr == phyirq_pkg::ADDR_CONFIG)
         || (apb_req.paddr == gaddr[0]) || (apb_req.paddr == gaddr[1])
         || (apb_req.paddr == gaddr[2]);
   end

   always_comb begin
      pending = 1'b0;
      for (int g = 0; g < phyirq_pkg::GROUPS; g++) begin
         flag_next[g] = flag_reg[g];
         en_next[g] = en_reg[g];
         // RULE24 clear on read of the group
         if (acc_rd && apb_req.paddr == gaddr[g]) begin
            flag_next[g] = 8'h00;
         end
         // RULE24 latch event, set wins over read clear
         flag_next[g] = (flag_next[g] | ev[g]) & fmask[g];
         // RULE6 RULE11 RULE17 writable enables
         if (acc_wr && apb_req.paddr == gaddr[g]) begin
            en_next[g] = apb_req.pwdata[7:0] & emask[g];
         end
         // RULE23 flag paired with enable eight below
         pending = pending | (|(flag_reg[g] & en_reg[g]));
      end
      cfg_next = cfg_reg;
      if (acc_wr && apb_req.paddr == phyirq_pkg::ADDR_CONFIG) begin
         cfg_next = apb_req.pwdata[3:0] & phyirq_pkg::CFG_WRITE_MASK;
      end
      // RULE19 global enable, RULE21 force
      active = (cfg_reg[phyirq_pkg::CFG_ENABLE_BIT] && pending)
         || cfg_reg[phyirq_pkg::CFG_FORCE_BIT];
      // RULE20 polarity select, one is active low
      irq_next = cfg_reg[phyirq_pkg::CFG_POLARITY_BIT] ? !active : active;
      // RULE22 sticky pin status, set wins over clear
      pin_sticky_next = pin_sticky_reg;
      if (acc_rd && apb_req.paddr == gaddr[0]) begin
         pin_sticky_next = 1'b0;
      end
      if (active) begin
         pin_sticky_next = 1'b1;
      end
   end

   always_comb begin
      prdata_next = 32'h0000_0000;
      pready_next = setup;
      pslverr_next = setup && !hit;
      if (acc_rd) begin
         if (apb_req.paddr == phyirq_pkg::ADDR_CONTROL) begin
            prdata_next[phyirq_pkg::CTRL_PIN_STATUS_BIT] = pin_sticky_reg;
         end
         if (apb_req.paddr == phyirq_pkg::ADDR_CONFIG) begin
            prdata_next[3:0] = cfg_reg;
         end
         for (int g = 0; g < phyirq_pkg::GROUPS; g++) begin
            if (apb_req.paddr == gaddr[g]) begin
               prdata_next[15:0] = {flag_reg[g], en_reg[g]};
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int g = 0; g < phyirq_pkg::GROUPS; g++) begin
            flag_reg[g] <= 8'h00;
         end
         // RULE18 power-on-done enable resets set
         en_reg[0] <= phyirq_pkg::EN_RESET_LINK;
         en_reg[1] <= phyirq_pkg::EN_RESET_SUPPLY;
         en_reg[2] <= phyirq_pkg::EN_RESET_WAKE;
         cfg_reg <= phyirq_pkg::CFG_RESET;
         pin_sticky_reg <= 1'b0;
         irq_reg <= 1'b1;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         for (int g = 0; g < phyirq_pkg::GROUPS; g++) begin
            flag_reg[g] <= flag_next[g];
            en_reg[g] <= en_next[g];
         end
         cfg_reg <= cfg_next;
         pin_sticky_reg <= pin_sticky_next;
         irq_reg <= irq_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq_pin = irq_reg;

   // RULE10 not-one-hot flag has no enable
   chk_oh_no_enable: assert property ( // RULE10
      !en_reg[1][0])
      else $error("not-one-hot enable set");

   // RULE1 link quality latch
   chk_lq_latch: assert property ( // RULE1
      link_ev.link_quality_low
      |=> flag_reg[0][7])
      else $error("link quality not latched");

   // RULE2 energy change latch
   chk_energy_latch: assert property ( // RULE2
      link_ev.energy_change
      |=> flag_reg[0][6])
      else $error("energy change not latched");

   // RULE3 link change latch
   chk_linkchg_latch: assert property ( // RULE3
      link_ev.link_change
      |=> flag_reg[0][5])
      else $error("link change not latched");

   // RULE4 discharge fault latch
   chk_esd_latch: assert property ( // RULE4
      link_ev.esd_fault
      |=> flag_reg[0][3])
      else $error("discharge fault not latched");

   // RULE5 training done latch
   chk_train_latch: assert property ( // RULE5
      link_ev.training_done
      |=> flag_reg[0][2])
      else $error("training done not latched");

   // RULE7 undervoltage latch
   chk_uv_latch: assert property ( // RULE7
      supply_ev.undervoltage
      |=> flag_reg[1][7])
      else $error("undervoltage not latched");

   // RULE7 overvoltage latch
   chk_ov_latch: assert property ( // RULE7
      supply_ev.overvoltage
      |=> flag_reg[1][6])
      else $error("overvoltage not latched");

   // RULE8 overtemperature latch
   chk_ot_latch: assert property ( // RULE8
      supply_ev.overtemperature
      |=> flag_reg[1][3])
      else $error("overtemperature not latched");

   // RULE9 sleep change latch
   chk_sleep_latch: assert property ( // RULE9
      supply_ev.sleep_change
      |=> flag_reg[1][2])
      else $error("sleep change not latched");

   // RULE10 not-one-hot latch
   chk_oh_latch: assert property ( // RULE10
      supply_ev.not_one_hot
      |=> flag_reg[1][0])
      else $error("not-one-hot not latched");

   // RULE12 acknowledge latch
   chk_ack_latch: assert property ( // RULE12
      wake_ev.ack_received
      |=> flag_reg[2][7])
      else $error("acknowledge not latched");

   // RULE13 transmit-valid clear latch
   chk_txclr_latch: assert property ( // RULE13
      wake_ev.tx_valid_clear
      |=> flag_reg[2][6])
      else $error("transmit-valid clear not latched");

   // RULE14 power-on done latch
   chk_por_latch: assert property ( // RULE14
      wake_ev.por_done
      |=> flag_reg[2][3])
      else $error("power-on done not latched");

   // RULE15 frame absence latch
   chk_noframe_latch: assert property ( // RULE15
      wake_ev.no_frame
      |=> flag_reg[2][2])
      else $error("frame absence not latched");

   // RULE16 wake request latch
   chk_wake_latch: assert property ( // RULE16
      wake_ev.wake_request
      |=> flag_reg[2][1])
      else $error("wake request not latched");

   // RULE16 sleep request latch
   chk_sleepreq_latch: assert property ( // RULE16
      wake_ev.low_power_sleep_request
      |=> flag_reg[2][0])
      else $error("sleep request not latched");

   // RULE24 clear on read
   chk_flag_read_clr: assert property ( // RULE24
      (acc_rd && apb_req.paddr == phyirq_pkg::ADDR_SUPPLY && supply_ev == '0)
      |=> flag_reg[1] == 8'h00)
      else $error("flags not cleared by read");

   // RULE24 link group clear on read
   chk_link_read_clr: assert property ( // RULE24
      (acc_rd && apb_req.paddr == phyirq_pkg::ADDR_LINK && link_ev == '0)
      |=> flag_reg[0] == 8'h00)
      else $error("link flags not cleared");

   // RULE24 wake group clear on read
   chk_wake_read_clr: assert property ( // RULE24
      (acc_rd && apb_req.paddr == phyirq_pkg::ADDR_WAKE && wake_ev == '0)
      |=> flag_reg[2] == 8'h00)
      else $error("wake flags not cleared");

   // RULE24 event beats read clear
   chk_set_wins: assert property ( // RULE24
      (acc_rd && apb_req.paddr == phyirq_pkg::ADDR_LINK && link_ev.training_done)
      |=> flag_reg[0][2])
      else $error("event lost to read clear");

   // RULE24 flag holds until read
   chk_flag_hold: assert property ( // RULE24
      (flag_reg[2][3] && !(acc_rd && apb_req.paddr == phyirq_pkg::ADDR_WAKE))
      |=> flag_reg[2][3])
      else $error("flag dropped without read");

   // RULE21 force asserts pin
   chk_force_pin: assert property ( // RULE21
      cfg_reg[phyirq_pkg::CFG_FORCE_BIT]
      |=> irq_reg == !$past(cfg_reg[phyirq_pkg::CFG_POLARITY_BIT]))
      else $error("forced pin not asserted");

   // RULE19 disabled and unforced pin idle
   chk_global_off: assert property ( // RULE19
      (!cfg_reg[phyirq_pkg::CFG_ENABLE_BIT] && !cfg_reg[phyirq_pkg::CFG_FORCE_BIT])
      |=> irq_reg == $past(cfg_reg[phyirq_pkg::CFG_POLARITY_BIT]))
      else $error("pin active while off");

   // RULE23 pending event drives pin
   chk_pend_pin: assert property ( // RULE23
      (cfg_reg[phyirq_pkg::CFG_ENABLE_BIT] && pending)
      |=> irq_reg == !$past(cfg_reg[phyirq_pkg::CFG_POLARITY_BIT]))
      else $error("pending event not on pin");

   // RULE23 nothing pending leaves pin idle
   chk_idle_pin: assert property ( // RULE23
      (!cfg_reg[phyirq_pkg::CFG_FORCE_BIT] && !pending)
      |=> irq_reg == $past(cfg_reg[phyirq_pkg::CFG_POLARITY_BIT]))
      else $error("pin active with nothing pending");

   // RULE22 sticky follows active pin
   chk_sticky_set: assert property ( // RULE22
      active
      |=> pin_sticky_reg)
      else $error("sticky pin status missed");

   // RULE22 sticky cleared by link read
   chk_sticky_clear: assert property ( // RULE22
      (acc_rd && apb_req.paddr == phyirq_pkg::ADDR_LINK && !active)
      |=> !pin_sticky_reg)
      else $error("sticky pin status not cleared");

   // RULE22 sticky holds until link read
   chk_sticky_hold: assert property ( // RULE22
      (pin_sticky_reg && !(acc_rd && apb_req.paddr == phyirq_pkg::ADDR_LINK))
      |=> pin_sticky_reg)
      else $error("sticky pin status dropped");

   // RULE6 enable mask
   chk_enable_mask: assert property ( // RULE6
      (en_reg[0] & ~phyirq_pkg::EN_MASK_LINK) == 8'h00)
      else $error("reserved enable set");

   // RULE11 supply enable mask
   chk_supply_mask: assert property ( // RULE11
      (en_reg[1] & ~phyirq_pkg::EN_MASK_SUPPLY) == 8'h00)
      else $error("reserved supply enable set");

   // RULE17 wake enable mask
   chk_wake_mask: assert property ( // RULE17
      (en_reg[2] & ~phyirq_pkg::EN_MASK_WAKE) == 8'h00)
      else $error("reserved wake enable set");

   // RULE6 link enable write effect
   chk_link_write: assert property ( // RULE6
      (acc_wr && apb_req.paddr == phyirq_pkg::ADDR_LINK)
      |=> en_reg[0] == ($past(apb_req.pwdata[7:0]) & phyirq_pkg::EN_MASK_LINK))
      else $error("link enable write lost");

   // RULE11 supply enable write effect
   chk_supply_write: assert property ( // RULE11
      (acc_wr && apb_req.paddr == phyirq_pkg::ADDR_SUPPLY)
      |=> en_reg[1] == ($past(apb_req.pwdata[7:0]) & phyirq_pkg::EN_MASK_SUPPLY))
      else $error("supply enable write lost");

   // RULE17 wake enable write effect
   chk_wake_write: assert property ( // RULE17
      (acc_wr && apb_req.paddr == phyirq_pkg::ADDR_WAKE)
      |=> en_reg[2] == ($past(apb_req.pwdata[7:0]) & phyirq_pkg::EN_MASK_WAKE))
      else $error("wake enable write lost");

   // Answer in the access cycle
   chk_ready_after_setup: assert property (
      setup
      |=> pready_reg)
      else $error("no ready after setup");

   // Answer stands one cycle
   chk_ready_pulse: assert property (
      pready_reg
      |=> !pready_reg)
      else $error("ready held too long");

   // Error only with the answer
   chk_err_ready: assert property (
      pslverr_reg
      |-> pready_reg)
      else $error("error without ready");

   // Unmapped write leaves the configuration unchanged
   chk_err_no_write: assert property (
      (setup && apb_req.pwrite && !hit)
      |=> cfg_reg == $past(cfg_reg))
      else $error("unmapped write took effect");

   // RULE1 link group read data
   chk_read_link: assert property ( // RULE1
      (acc_rd && apb_req.paddr == phyirq_pkg::ADDR_LINK)
      |=> prdata_reg == {16'h0000, $past(flag_reg[0]), $past(en_reg[0])})
      else $error("link read data wrong");

   // RULE7 supply group read data
   chk_read_supply: assert property ( // RULE7
      (acc_rd && apb_req.paddr == phyirq_pkg::ADDR_SUPPLY)
      |=> prdata_reg == {16'h0000, $past(flag_reg[1]), $past(en_reg[1])})
      else $error("supply read data wrong");

   // RULE12 wake group read data
   chk_read_wake: assert property ( // RULE12
      (acc_rd && apb_req.paddr == phyirq_pkg::ADDR_WAKE)
      |=> prdata_reg == {16'h0000, $past(flag_reg[2]), $past(en_reg[2])})
      else $error("wake read data wrong");

   // RULE20 configuration read data
   chk_read_config: assert property ( // RULE20
      (acc_rd && apb_req.paddr == phyirq_pkg::ADDR_CONFIG)
      |=> prdata_reg == {28'h0000000, $past(cfg_reg)})
      else $error("config read data wrong");

   // RULE22 control read data
   chk_read_control: assert property ( // RULE22
      (acc_rd && apb_req.paddr == phyirq_pkg::ADDR_CONTROL)
      |=> prdata_reg[phyirq_pkg::CTRL_PIN_STATUS_BIT] == $past(pin_sticky_reg))
      else $error("control read data wrong");

   cov_irq_low: cover property ($fell(irq_reg));
   cov_read_clear: cover property (
      flag_reg[0] != 8'h00 ##1 flag_reg[0] == 8'h00);
   cov_err: cover property (pslverr_reg);
   cov_force: cover property (cfg_reg[phyirq_pkg::CFG_FORCE_BIT]);
   cov_wake_flag: cover property (flag_reg[2] != 8'h00);
endmodule : phyirq_top
